//--- dma_addr_regs.svh
// Register indices, field positions and constants for the channel address block
`ifndef DMA_ADDR_REGS_SVH
`define DMA_ADDR_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_W              20
`define MEM_ADDR_A_IDX     20'hfff20
`define MEM_ADDR_B_IDX     20'hfff28
`define IO_ADDR_A_IDX      20'hfff26
`define IO_ADDR_B_IDX      20'hfff2e
`define STEP_CTRL_IDX      20'hfff2f

// Bus widths
`define BUS_ADDR_W         22
`define BUS_DATA_W         32
`define BUS_BE_W           4

// Memory address register layout
`define MEM_ADDR_W         24
`define MEM_HIGH_ONES      8'hff
`define MEM_ADDR_RESET     24'h000000

// I/O address register layout
`define IO_ADDR_W          8
`define IO_ADDR_RESET      8'h00
`define IO_PAGE            16'hffff

// Step control register fields
`define STEP_EN_BIT        4
`define STEP_DIR_BIT       5
`define STEP_CTRL_RESET    2'h0

// Step sizes per transfer
`define STEP_BYTE          24'h000001
`define STEP_WORD          24'h000002

`endif

//--- dma_addr_pkg.sv
// Types shared by the channel address block
`default_nettype none

package dma_addr_pkg;

  // 24-bit memory address field
  typedef logic [23:0] addr24_t;

  // 8-bit I/O address
  typedef logic [7:0] io_addr_t;

  // Bus handshake phase
  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_ACK  = 1'b1
  } bus_phase_e;

endpackage

`default_nettype wire

//--- byte_merge.sv
// Byte-lane write merge for one register
`timescale 1ns/1ps
`default_nettype none

module byte_merge #(
  parameter int WIDTH = 32
) (
  input  wire logic [WIDTH-1:0]   old_value,
  input  wire logic [WIDTH-1:0]   wdata,
  input  wire logic [WIDTH/8-1:0] byte_en,
  output logic      [WIDTH-1:0]   merged
);

  // Each enabled lane takes write data, the rest keep the old value
  genvar lane;
  generate
    for (lane = 0; lane < WIDTH / 8; lane++)
    begin : g_lane
      assign merged[lane*8 +: 8] = byte_en[lane] ? wdata[lane*8 +: 8]
                                                 : old_value[lane*8 +: 8];
    end
  endgenerate

endmodule

`default_nettype wire

//--- addr_stepper.sv
// Next-value logic for the second memory address after a transfer
`timescale 1ns/1ps
`default_nettype none
`include "dma_addr_regs.svh"

module addr_stepper (
  input  wire logic                   step_enable,
  input  wire logic                   step_down,
  input  wire logic                   transfer_size,
  input  wire dma_addr_pkg::addr24_t  cur_addr,
  output dma_addr_pkg::addr24_t       next_addr
);

  // Step amount by transfer size
  dma_addr_pkg::addr24_t step;

  // Byte moves by one, word by two
  always_comb
  begin
    step = transfer_size ? `STEP_WORD : `STEP_BYTE;
    if (!step_enable)
    begin
      next_addr = cur_addr;
    end
    else if (step_down)
    begin
      // 24-bit difference wraps within the field
      next_addr = cur_addr - step;
    end
    else
    begin
      // 24-bit sum wraps within the field
      next_addr = cur_addr + step;
    end
  end

endmodule

`default_nettype wire

//--- dma_channel_address_regs.sv
// Channel 0 address registers with Avalon-MM slave and address stepping
`timescale 1ns/1ps
`default_nettype none
`include "dma_addr_regs.svh"

module dma_channel_address_regs (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic [`BUS_ADDR_W-1:0]      avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [`BUS_DATA_W-1:0]      avs_writedata,
  input  wire logic [`BUS_BE_W-1:0]        avs_byteenable,
  output logic      [`BUS_DATA_W-1:0]      avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        transfer_size,
  input  wire logic                        short_addr_mode,
  input  wire logic                        xfer_done,
  output logic      [`MEM_ADDR_W-1:0]      addr_a_out,
  output logic      [`MEM_ADDR_W-1:0]      addr_b_out
);

  // All block state in one record
  typedef struct packed {
    dma_addr_pkg::addr24_t    mem_a;      // First memory address field
    dma_addr_pkg::addr24_t    mem_b;      // Second memory address field
    dma_addr_pkg::io_addr_t   io_a;       // First I/O address
    dma_addr_pkg::io_addr_t   io_b;       // Second I/O address
    logic                     step_en;    // Destination step enable
    logic                     step_dir;   // Destination step direction
    dma_addr_pkg::bus_phase_e phase;      // Bus handshake phase
    logic                     waitreq;    // Registered waitrequest
    logic [`BUS_DATA_W-1:0]   rdata;      // Registered read data
    dma_addr_pkg::addr24_t    out_a;      // Registered first address out
    dma_addr_pkg::addr24_t    out_b;      // Registered second address out
  } state_s;

  state_s state_reg;                      // Current state
  state_s state_next;                     // Next state

  // Byte addresses of the registers, four times the index
  localparam logic [`BUS_ADDR_W-1:0] MEM_A_ADDR = {`MEM_ADDR_A_IDX, 2'b00};
  localparam logic [`BUS_ADDR_W-1:0] MEM_B_ADDR = {`MEM_ADDR_B_IDX, 2'b00};
  localparam logic [`BUS_ADDR_W-1:0] IO_A_ADDR  = {`IO_ADDR_A_IDX, 2'b00};
  localparam logic [`BUS_ADDR_W-1:0] IO_B_ADDR  = {`IO_ADDR_B_IDX, 2'b00};
  localparam logic [`BUS_ADDR_W-1:0] CTRL_ADDR  = {`STEP_CTRL_IDX, 2'b00};

  // Address decode hits
  logic hit_mem_a;                        // First memory address selected
  logic hit_mem_b;                        // Second memory address selected
  logic hit_io_a;                         // First I/O address selected
  logic hit_io_b;                         // Second I/O address selected
  logic hit_ctrl;                         // Step control selected

  // Views as software sees them: full 32-bit memory addresses, step control byte
  logic [`BUS_DATA_W-1:0] mem_a_view;     // First memory address, top ones
  logic [`BUS_DATA_W-1:0] mem_b_view;     // Second memory address, top ones
  logic [7:0]             ctrl_view;      // Step control byte

  // Merged write values per register
  logic [`BUS_DATA_W-1:0] mem_a_merged;   // First memory address after write
  logic [`BUS_DATA_W-1:0] mem_b_merged;   // Second memory address after write
  logic [7:0]             io_a_merged;    // First I/O address after write
  logic [7:0]             io_b_merged;    // Second I/O address after write
  logic [7:0]             ctrl_merged;    // Step control after write

  // Stepped second memory address
  dma_addr_pkg::addr24_t  mem_b_stepped;  // Value after one transfer

  // Write commit strobe, true only on the completing edge
  logic                   wr_commit;      // Write lands this edge

  // Decode compares the whole byte address
  always_comb
  begin
    hit_mem_a = (avs_address == MEM_A_ADDR);
    hit_mem_b = (avs_address == MEM_B_ADDR);
    hit_io_a  = (avs_address == IO_A_ADDR);
    hit_io_b  = (avs_address == IO_B_ADDR);
    hit_ctrl  = (avs_address == CTRL_ADDR);
  end

  // Software views; upper byte is hardwired to ones
  always_comb
  begin
    mem_a_view = {`MEM_HIGH_ONES, state_reg.mem_a};
    mem_b_view = {`MEM_HIGH_ONES, state_reg.mem_b};
    ctrl_view  = 8'h00;
    ctrl_view[`STEP_EN_BIT]  = state_reg.step_en;
    ctrl_view[`STEP_DIR_BIT] = state_reg.step_dir;
  end

  // Byte-lane merges; narrow registers live in lane zero
  byte_merge #(
    .WIDTH (32)
  ) u_merge_mem_a (
    .old_value (mem_a_view),
    .wdata     (avs_writedata),
    .byte_en   (avs_byteenable),
    .merged    (mem_a_merged)
  );

  byte_merge #(
    .WIDTH (32)
  ) u_merge_mem_b (
    .old_value (mem_b_view),
    .wdata     (avs_writedata),
    .byte_en   (avs_byteenable),
    .merged    (mem_b_merged)
  );

  byte_merge #(
    .WIDTH (8)
  ) u_merge_io_a (
    .old_value (state_reg.io_a),
    .wdata     (avs_writedata[7:0]),
    .byte_en   (avs_byteenable[0]),
    .merged    (io_a_merged)
  );

  byte_merge #(
    .WIDTH (8)
  ) u_merge_io_b (
    .old_value (state_reg.io_b),
    .wdata     (avs_writedata[7:0]),
    .byte_en   (avs_byteenable[0]),
    .merged    (io_b_merged)
  );

  byte_merge #(
    .WIDTH (8)
  ) u_merge_ctrl (
    .old_value (ctrl_view),
    .wdata     (avs_writedata[7:0]),
    .byte_en   (avs_byteenable[0]),
    .merged    (ctrl_merged)
  );

  // Second address stepping from the registered control bits
  addr_stepper u_stepper (
    .step_enable   (state_reg.step_en),
    .step_down     (state_reg.step_dir),
    .transfer_size (transfer_size),
    .cur_addr      (state_reg.mem_b),
    .next_addr     (mem_b_stepped)
  );

  // Write lands only on the edge where waitrequest is seen low
  always_comb
  begin
    wr_commit = avs_write && (state_reg.phase == dma_addr_pkg::PH_ACK);
  end

  // Next-state logic for bus, registers and address outputs
  always_comb
  begin
    state_next = state_reg;

    // Handshake: one wait cycle, then a one-cycle answer
    unique case (state_reg.phase)
      dma_addr_pkg::PH_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          // Accept and drop waitrequest for the next cycle
          state_next.phase   = dma_addr_pkg::PH_ACK;
          state_next.waitreq = 1'b0;
          // Read data captured now so it stands through the answer
          if (hit_mem_a)
          begin
            state_next.rdata = mem_a_view;
          end
          else if (hit_mem_b)
          begin
            state_next.rdata = mem_b_view;
          end
          else if (hit_io_a)
          begin
            state_next.rdata = {24'h000000, state_reg.io_a};
          end
          else if (hit_io_b)
          begin
            state_next.rdata = {24'h000000, state_reg.io_b};
          end
          else if (hit_ctrl)
          begin
            state_next.rdata = {24'h000000, ctrl_view};
          end
          else
          begin
            // Unmapped addresses read as zero
            state_next.rdata = 32'h00000000;
          end
        end
      end
      dma_addr_pkg::PH_ACK:
      begin
        // Answer given this edge; back to waiting
        state_next.phase   = dma_addr_pkg::PH_IDLE;
        state_next.waitreq = 1'b1;
      end
    endcase

    // Transfer completion steps the second address
    if (xfer_done)
    begin
      state_next.mem_b = mem_b_stepped;
    end

    // Software writes; a write beats a same-edge step so the
    // value software just loaded is the one the next transfer uses
    if (wr_commit)
    begin
      if (hit_mem_a)
      begin
        // Upper byte of the merge is dropped, it is not writable
        state_next.mem_a = mem_a_merged[`MEM_ADDR_W-1:0];
      end
      if (hit_mem_b)
      begin
        state_next.mem_b = mem_b_merged[`MEM_ADDR_W-1:0];
      end
      if (hit_io_a)
      begin
        state_next.io_a = io_a_merged;
      end
      if (hit_io_b)
      begin
        state_next.io_b = io_b_merged;
      end
      if (hit_ctrl)
      begin
        state_next.step_en  = ctrl_merged[`STEP_EN_BIT];
        state_next.step_dir = ctrl_merged[`STEP_DIR_BIT];
      end
      // Unmapped writes are ignored
    end

    // Address outputs; I/O address only counts in short mode
    if (short_addr_mode)
    begin
      state_next.out_a = {`IO_PAGE, state_next.io_a};
      state_next.out_b = {`IO_PAGE, state_next.io_b};
    end
    else
    begin
      // Full mode ignores the I/O registers entirely
      state_next.out_a = state_next.mem_a;
      state_next.out_b = state_next.mem_b;
    end
  end

  // Single state register; reset values are constants only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // Address contents are undefined to software; zero is chosen
      state_reg.mem_a    <= `MEM_ADDR_RESET;
      state_reg.mem_b    <= `MEM_ADDR_RESET;
      state_reg.io_a     <= `IO_ADDR_RESET;
      state_reg.io_b     <= `IO_ADDR_RESET;
      state_reg.step_en  <= 1'b0;
      state_reg.step_dir <= 1'b0;
      state_reg.phase    <= dma_addr_pkg::PH_IDLE;
      // Waitrequest idles high so no request slips through
      state_reg.waitreq  <= 1'b1;
      state_reg.rdata    <= 32'h00000000;
      state_reg.out_a    <= `MEM_ADDR_RESET;
      state_reg.out_b    <= `MEM_ADDR_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata    = state_reg.rdata;
  assign avs_waitrequest = state_reg.waitreq;
  assign addr_a_out      = state_reg.out_a;
  assign addr_b_out      = state_reg.out_b;

endmodule

`default_nettype wire

//--- dma_channel_address_regs_monitor.sv
// Port checker for the channel address block
`timescale 1ns/1ps
`default_nettype none
`include "dma_addr_regs.svh"

module dma_channel_address_regs_monitor (
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic [`BUS_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [`BUS_DATA_W-1:0] avs_writedata,
  input wire logic [`BUS_BE_W-1:0]   avs_byteenable,
  input wire logic [`BUS_DATA_W-1:0] avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic                   transfer_size,
  input wire logic                   short_addr_mode,
  input wire logic                   xfer_done,
  input wire logic [`MEM_ADDR_W-1:0] addr_a_out,
  input wire logic [`MEM_ADDR_W-1:0] addr_b_out
);
  logic en_reg;   // Mirrored step enable
  logic dir_reg;  // Mirrored step direction
  logic wr_done;  // Write completes at this edge
  logic rd_done;  // Read completes at this edge
  logic mem_hit;  // Read aims at a memory address register
  logic io_hit;   // Read aims at an I/O address register
  assign wr_done = avs_write && !avs_waitrequest;
  assign rd_done = avs_read && !avs_waitrequest;
  assign mem_hit = avs_address == {`MEM_ADDR_A_IDX, 2'b00}
                || avs_address == {`MEM_ADDR_B_IDX, 2'b00};
  assign io_hit = avs_address == {`IO_ADDR_A_IDX, 2'b00}
               || avs_address == {`IO_ADDR_B_IDX, 2'b00};

  // Step control copy, only lane 0 carries its bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_reg <= 1'b0;
      dir_reg <= 1'b0;
    end
    else if (wr_done && avs_byteenable[0] && avs_address == {`STEP_CTRL_IDX, 2'b00})
    begin
      en_reg <= avs_writedata[`STEP_EN_BIT];
      dir_reg <= avs_writedata[`STEP_DIR_BIT];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Any completed write is left out: a write to the second address wins over a step
  a_mem_top_ones: assert property (
    rd_done && mem_hit |-> avs_readdata[31:24] == `MEM_HIGH_ONES)
    else $error("memory address top byte not all ones");
  a_io_upper_zero: assert property (
    rd_done && io_hit |-> avs_readdata[31:8] == 24'h000000)
    else $error("io address upper bits not zero");
  // Mode must be full on both edges, else the output view itself switched
  a_step_hold: assert property (
    xfer_done && !en_reg && !short_addr_mode && !$past(short_addr_mode) && !wr_done
    |=> $stable(addr_b_out))
    else $error("second address moved with stepping off");
  a_step_up: assert property (
    xfer_done && en_reg && !dir_reg && !short_addr_mode && !$past(short_addr_mode) && !wr_done
    |=> addr_b_out == $past(addr_b_out) + ($past(transfer_size) ? `STEP_WORD : `STEP_BYTE))
    else $error("second address increment wrong");
  a_step_down: assert property (
    xfer_done && en_reg && dir_reg && !short_addr_mode && !$past(short_addr_mode) && !wr_done
    |=> addr_b_out == $past(addr_b_out) - ($past(transfer_size) ? `STEP_WORD : `STEP_BYTE))
    else $error("second address decrement wrong");
  a_short_page: assert property (
    short_addr_mode && $past(short_addr_mode)
    |-> addr_a_out[23:8] == `IO_PAGE && addr_b_out[23:8] == `IO_PAGE)
    else $error("short mode page wrong");
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("answer not exactly one cycle after request");
  a_wait_idle: assert property (
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");

  c_step_up: cover property (xfer_done && en_reg && !dir_reg);
  c_step_down: cover property (xfer_done && en_reg && dir_reg);
  c_short: cover property (short_addr_mode && rd_done);
endmodule

bind dma_channel_address_regs dma_channel_address_regs_monitor dma_channel_address_regs_monitor_inst (
  .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .transfer_size(transfer_size),
  .short_addr_mode(short_addr_mode), .xfer_done(xfer_done), .addr_a_out(addr_a_out),
  .addr_b_out(addr_b_out));
`default_nettype wire

//--- xfer_source.sv
// Transfer side model: a burst of completed-transfer pulses
`timescale 1ns/1ps
`default_nettype none

module xfer_source (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic [3:0] count,
  input  wire logic       size_in,
  output logic            xfer_done,
  output logic            transfer_size,
  output logic            busy
);
  logic [3:0] left_reg;  // Pulses still to send
  assign busy = left_reg != 4'h0 || xfer_done;

  // Pulses run back to back, the harshest spacing the design accepts
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      left_reg <= 4'h0;
      xfer_done <= 1'b0;
      transfer_size <= 1'b0;
    end
    else
    begin
      if (go && left_reg == 4'h0)
      begin
        left_reg <= count;
        transfer_size <= size_in;  // Held for the whole burst
      end
      else if (left_reg != 4'h0)
        left_reg <= left_reg - 4'h1;
      xfer_done <= left_reg != 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- dma_channel_address_regs_tb.sv
// Self-checking bench for the channel address block
`timescale 1ns/1ps
`default_nettype none
`include "dma_addr_regs.svh"

module dma_channel_address_regs_tb;
  logic clk, resetn, avs_read, avs_write, avs_waitrequest, short_addr_mode;
  logic transfer_size, xfer_done, go, size_in, busy;
  logic [21:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable, count;
  logic [23:0] addr_a_out, addr_b_out;
  int err_count, tests_run;
  typedef struct { logic [19:0] idx; logic [31:0] wd; logic [3:0] be; logic [31:0] exp; } row_s;
  typedef struct { logic [7:0] ctrl; logic sz; logic [3:0] n; logic [23:0] st, exp; } step_s;
  // Register rows: write, then read back
  // Last row: lane 0 off leaves the I/O register untouched
  row_s rows [8] = '{
    '{`MEM_ADDR_A_IDX, 32'h12345678, 4'hf, 32'hff345678},
    '{`MEM_ADDR_A_IDX, 32'h000000ef, 4'h1, 32'hff3456ef},
    '{`IO_ADDR_A_IDX, 32'hffffff5a, 4'h1, 32'h0000005a},
    '{`IO_ADDR_B_IDX, 32'h000000a5, 4'h1, 32'h000000a5},
    '{`MEM_ADDR_B_IDX, 32'h00fffffe, 4'hf, 32'hfffffffe},
    '{`STEP_CTRL_IDX, 32'h000000ff, 4'h1, 32'h00000030},
    '{20'hfff21, 32'hffffffff, 4'hf, 32'h00000000},
    '{`IO_ADDR_B_IDX, 32'h000000ff, 4'he, 32'h000000a5}};
  // Step rows: control, size, pulses, start, result; wrap cases included
  step_s steps [6] = '{'{8'h00, 1'b1, 4'h1, 24'h000100, 24'h000100},
    '{8'h20, 1'b0, 4'h1, 24'h000100, 24'h000100}, '{8'h10, 1'b0, 4'h1, 24'h000100, 24'h000101},
    '{8'h10, 1'b1, 4'h2, 24'hfffffe, 24'h000002}, '{8'h30, 1'b0, 4'h1, 24'h000000, 24'hffffff},
    '{8'h30, 1'b1, 4'h3, 24'h000010, 24'h00000a}};

  dma_channel_address_regs dma_channel_address_regs_inst (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .transfer_size(transfer_size),
    .short_addr_mode(short_addr_mode), .xfer_done(xfer_done), .addr_a_out(addr_a_out),
    .addr_b_out(addr_b_out));
  xfer_source xfer_source_inst (.clk(clk), .resetn(resetn), .go(go), .count(count),
    .size_in(size_in), .xfer_done(xfer_done), .transfer_size(transfer_size), .busy(busy));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task bus(input logic wr, input logic [19:0] idx, input logic [31:0] wd, input logic [3:0] be);
    int n;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      $display("ERROR waitrequest expected 0 seen 1");
      err_count++;
      results();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Burst of transfers, then wait for the model to go quiet
  task burst(input logic [3:0] n, input logic sz);
    int k;
    @(posedge clk);
    count <= n;
    size_in <= sz;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    // Model loads on this edge; its busy flag is seen only from the next
    @(posedge clk);
    k = 0;
    while (busy !== 1'b0 && k < 30)
    begin
      @(posedge clk);
      k++;
    end
    if (busy !== 1'b0)
    begin
      $display("ERROR burst busy expected 0 seen 1");
      err_count++;
      results();
    end
    repeat (2) @(posedge clk);
  endtask

  initial
  begin
    resetn = 1'b0;
    {avs_read, avs_write, short_addr_mode, go, size_in} = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = '0;
    count = '0;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    chk("waitrequest in reset", 32'h1, {31'h0, avs_waitrequest});
    chk("addr_b_out in reset", 32'h0, {8'h0, addr_b_out});
    resetn <= 1'b1;
    bus(1'b0, `MEM_ADDR_A_IDX, '0, 4'hf);
    chk("mem_a after reset", 32'hff000000, rd);
    $display("test reset done");
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].idx, rows[i].wd, rows[i].be);
      bus(1'b0, rows[i].idx, '0, 4'hf);
      chk("register readback", rows[i].exp, rd);
    end
    $display("test registers done");
    foreach (steps[i])
    begin
      bus(1'b1, `STEP_CTRL_IDX, {24'h0, steps[i].ctrl}, 4'h1);
      bus(1'b1, `MEM_ADDR_B_IDX, {8'h0, steps[i].st}, 4'hf);
      burst(steps[i].n, steps[i].sz);
      chk("addr_b_out", {8'h0, steps[i].exp}, {8'h0, addr_b_out});
      bus(1'b0, `MEM_ADDR_B_IDX, '0, 4'hf);
      chk("mem_b", {8'hff, steps[i].exp}, rd);
    end
    $display("test stepping done");
    // Short mode takes the I/O addresses on the fixed page
    bus(1'b1, `IO_ADDR_A_IDX, 32'h0000005a, 4'h1);
    short_addr_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk("addr_a_out short", 32'h00ffff5a, {8'h0, addr_a_out});
    chk("addr_b_out short", 32'h00ffffa5, {8'h0, addr_b_out});
    bus(1'b0, `IO_ADDR_B_IDX, '0, 4'hf);
    chk("io_b in short mode", 32'h000000a5, rd);
    short_addr_mode <= 1'b0;
    repeat (3) @(posedge clk);
    chk("addr_a_out full", 32'h003456ef, {8'h0, addr_a_out});
    $display("test short mode done");
    // Second reset in mid-run clears stepping and outputs
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chk("addr_b_out reset", 32'h0, {8'h0, addr_b_out});
    bus(1'b0, `STEP_CTRL_IDX, '0, 4'hf);
    chk("step control reset", 32'h0, rd);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
